// ===== src/irq_status_pkg.sv
// Constants, register map and carrier types of the charger and rail
// interrupt status block.
// Assumes one 10 MHz clock and a two-wire serial host on the far side.
package irq_status_pkg;

    // Register offsets on the serial interface.
    localparam logic [7:0] CHG_STATUS_OFS = 8'h01;
    localparam logic [7:0] RAIL_STATUS_OFS = 8'h02;
    localparam logic [7:0] CHG_MASK_OFS = 8'h03;
    localparam logic [7:0] RAIL_MASK_OFS = 8'h04;
    localparam logic [7:0] CHG_ACK_OFS = 8'h05;
    localparam logic [7:0] RAIL_ACK_OFS = 8'h06;

    // Reset values and read-back of an unmapped offset.
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] ACK_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;

    // Field groups: edge-set bits, host-clearable bits, used rail bits.
    localparam logic [7:0] CHG_EDGE_BITS = 8'h21;
    localparam logic [7:0] CHG_HOST_CLEAR_BITS = 8'h1e;
    localparam logic [7:0] RAIL_EDGE_BITS = 8'he0;
    localparam logic [7:0] RAIL_USED_BITS = 8'hef;

    // Serial target address: six fixed upper bits, strap gives the lsb.
    localparam logic [5:0] TARGET_ADDR_HI = 6'h24;
    localparam int unsigned SYNC_DEPTH = 2;
    localparam int unsigned BYTE_BITS = 8;

    // Charger condition inputs, bit 7 first.
    typedef struct packed {
        logic usb_valid;
        logic ac_valid;
        logic thermal_suspend;
        logic term_current;
        logic taper_timeout;
        logic chg_timeout;
        logic prechg_timeout;
        logic battery_temp_fault;
    } charger_src_t;

    // Rail condition inputs, bit 6 first; status bit 4 has no source.
    typedef struct packed {
        logic pushbutton_off_request;
        logic battery_lid_input;
        logic supply_undervoltage;
        logic aux_reg2_fault;
        logic aux_reg1_fault;
        logic main_buck_fault;
        logic core_buck_fault;
    } rail_src_t;

    // Control bits that live in other registers of the same clock domain.
    typedef struct packed {
        logic aux_reg2_enable;
        logic aux_reg1_enable;
        logic core_lp_flag;
        logic low_power_mode;
    } rail_ctrl_t;

    // Serial interface phases.
    typedef enum logic [3:0] {
        SER_IDLE, SER_ADDR, SER_ACK_ADDR, SER_REG, SER_ACK_REG,
        SER_WRITE, SER_ACK_WRITE, SER_READ, SER_ACK_READ
    } ser_state_t;

endpackage

// ===== src/charger_rail_irq_status.sv
// Interrupt status, mask and acknowledge registers of the charger and
// supply rails, reached by a two-wire serial target on scl and sda.
// Assumes condition inputs and pins are asynchronous to clk, control bits
// of rail_ctrl come from the same clock, and scl runs at 400 kHz at most.
module charger_rail_irq_status
    import irq_status_pkg::*;
#(
    parameter int unsigned SYNC_STAGES = irq_status_pkg::SYNC_DEPTH
) (
    // Clock and reset.
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Serial interface pins; sda is open drain.
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    input  wire logic                         addr_lsb_strap,
    // Condition sources.
    input  wire irq_status_pkg::charger_src_t charger_src,
    input  wire irq_status_pkg::rail_src_t    rail_src,
    input  wire irq_status_pkg::rail_ctrl_t   rail_ctrl,
    // Charger reset request, one cycle.
    output logic                              charger_reset,
    // Open-drain interrupt pin, active low.
    output logic                              irq_n_out,
    output logic                              irq_oe
);
    import irq_status_pkg::*;

    localparam int unsigned SYNC_W = 18;
    // Chain reset value: scl and sda idle high, all source bits low.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'b11, 16'h0000};

    // Fewer than two stages would let metastability reach the logic.
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2.");
    end

    // Synchroniser chain and its decoded taps.
    logic [SYNC_W-1:0] sync_q [SYNC_STAGES];
    logic [SYNC_W-1:0] synced;
    logic [SYNC_W-1:0] synced_prev;
    logic              scl_s;
    logic              sda_s;
    logic              strap_s;
    logic [7:0]        chg_src_s;
    logic [7:0]        rail_src_s;
    // Rising edges of the synchronised sources.
    logic [7:0]        chg_rise;
    logic [7:0]        rail_rise;
    // Registers that the host can read.
    logic [7:0]        charge_event_status;
    logic [7:0]        rail_event_status;
    logic [7:0]        charge_event_mask;
    logic [7:0]        rail_event_mask;
    logic [7:0]        charge_event_ack;
    logic [7:0]        rail_event_ack;
    // Internal state behind the status bits.
    logic [7:0]        chg_edge_q;
    logic [7:0]        rail_edge_q;
    logic [7:0]        host_cleared;
    logic [7:0]        chg_level;
    logic [7:0]        rail_level;
    logic [7:0]        next_chg_ack;
    logic [7:0]        next_rail_ack;
    // Serial target state.
    ser_state_t        ser_state;
    logic [7:0]        shift_in;
    logic [7:0]        shift_out;
    logic [3:0]        bit_cnt;
    logic [7:0]        reg_ptr;
    logic              read_dir;
    logic              master_ack;
    // Serial events and strobes, one cycle each; pending is the interrupt level.
    logic              scl_rise;
    logic              scl_fall;
    logic              start_seen;
    logic              stop_seen;
    logic              load_read;
    logic              wr_strobe;
    logic              pending;

    // Returns the value a host read of an offset shows.
    function automatic logic [7:0] read_value(input logic [7:0] ofs);
        unique case (ofs)
            CHG_STATUS_OFS:  read_value = charge_event_status;
            RAIL_STATUS_OFS: read_value = rail_event_status;
            CHG_MASK_OFS:    read_value = charge_event_mask;
            RAIL_MASK_OFS:   read_value = rail_event_mask;
            CHG_ACK_OFS:     read_value = charge_event_ack;
            RAIL_ACK_OFS:    read_value = rail_event_ack;
            default:         read_value = UNMAPPED_READ;
        endcase
    endfunction

    // Synchroniser chain of SYNC_STAGES stages for every asynchronous input.
    generate
        for (genvar s = 0; s < SYNC_STAGES; s++) begin : g_sync
            if (s == 0) begin : g_first
                // The first stage alone samples the pins.
                always_ff @(posedge clk) begin
                    if (!rst_n) begin
                        sync_q[s] <= SYNC_IDLE;
                    end else begin
                        sync_q[s] <= {scl_in, sda_in, addr_lsb_strap,
                                      charger_src, rail_src};
                    end
                end
            end else begin : g_next
                // Later stages only copy the stage before them.
                always_ff @(posedge clk) begin
                    if (!rst_n) begin
                        sync_q[s] <= SYNC_IDLE;
                    end else begin
                        sync_q[s] <= sync_q[s-1];
                    end
                end
            end
        end
    endgenerate

    assign synced     = sync_q[SYNC_STAGES-1];
    assign scl_s      = synced[17];
    assign sda_s      = synced[16];
    assign strap_s    = synced[15];
    assign chg_src_s  = synced[14:7];
    // Lid bit is set while the pin is low; bit 4 has no source.
    assign rail_src_s = {synced[6], ~synced[5], synced[4], 1'b0,
                         synced[3:0]};

    // Previous synchronised values, for edge detection.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            synced_prev <= SYNC_IDLE;
        end else begin
            synced_prev <= synced;
        end
    end

    assign scl_rise   = scl_s & ~synced_prev[17];
    assign scl_fall   = ~scl_s & synced_prev[17];
    assign start_seen = scl_s & synced_prev[17] & ~sda_s & synced_prev[16];
    assign stop_seen  = scl_s & synced_prev[17] & sda_s & ~synced_prev[16];
    assign chg_rise   = chg_src_s & ~synced_prev[14:7];
    assign rail_rise  = rail_src_s & ~{synced_prev[6], ~synced_prev[5],
                                       synced_prev[4], 1'b0,
                                       synced_prev[3:0]};

    // Edge-set charger and rail bits; a new edge wins over the clear.
    // An acknowledge alone never clears a bit whose source is still high.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chg_edge_q  <= STATUS_RESET;
            rail_edge_q <= STATUS_RESET;
        end else begin
            chg_edge_q  <= CHG_EDGE_BITS & (chg_rise |
                (chg_edge_q & ~(~chg_src_s & charge_event_ack)));
            rail_edge_q <= RAIL_EDGE_BITS & (rail_rise |
                (rail_edge_q & ~(~rail_src_s & rail_event_ack)));
        end
    end

    // Host clears of charger bits 4..1 hold the bit low until the source
    // drops, so a charger still reporting the old condition is not
    // reported twice.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_cleared  <= 8'h00;
            charger_reset <= 1'b0;
        end else begin
            host_cleared  <= (host_cleared & chg_src_s) |
                ((wr_strobe && reg_ptr == CHG_STATUS_OFS) ?
                 (CHG_HOST_CLEAR_BITS & charge_event_status & ~shift_in) :
                 8'h00);
            charger_reset <= wr_strobe && reg_ptr == CHG_STATUS_OFS &&
                |(CHG_HOST_CLEAR_BITS & charge_event_status & ~shift_in);
        end
    end

    // Level bits follow sources; aux bits need their enables, core_lp_flag and low_power_mode also set rail bit 0.
    assign chg_level = ~CHG_EDGE_BITS & chg_src_s & ~host_cleared;
    assign rail_level = {4'h0,
        rail_src_s[3] & rail_ctrl.aux_reg2_enable,
        rail_src_s[2] & rail_ctrl.aux_reg1_enable,
        rail_src_s[1],
        rail_src_s[0] | (rail_ctrl.core_lp_flag &
                         rail_ctrl.low_power_mode)};

    // Status registers as seen by the host.
    // One flop of lag keeps the read latch and acknowledge in step.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_event_status <= STATUS_RESET;
            rail_event_status   <= STATUS_RESET;
        end else begin
            charge_event_status <= chg_edge_q | chg_level;
            rail_event_status   <= RAIL_USED_BITS &
                                   (rail_edge_q | rail_level);
        end
    end

    // Acknowledge set by a status read, cleared with the status bit.
    // A set and a clear in one cycle leave the bit set only while the
    // status bit is still one.
    always_comb begin
        next_chg_ack  = charge_event_ack;
        next_rail_ack = rail_event_ack;
        if (load_read && reg_ptr == CHG_STATUS_OFS) begin
            next_chg_ack = charge_event_ack | charge_event_status;
        end
        if (load_read && reg_ptr == RAIL_STATUS_OFS) begin
            next_rail_ack = rail_event_ack | rail_event_status;
        end
        next_chg_ack  = next_chg_ack & charge_event_status;
        next_rail_ack = next_rail_ack & rail_event_status;
    end

    // Acknowledge flops; rail bit 4 never holds one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_event_ack <= ACK_RESET;
            rail_event_ack   <= ACK_RESET;
        end else begin
            charge_event_ack <= next_chg_ack;
            rail_event_ack   <= next_rail_ack & RAIL_USED_BITS;
        end
    end

    // Mask registers, written by the host.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_event_mask <= MASK_RESET;
            rail_event_mask   <= MASK_RESET;
        end else if (wr_strobe) begin
            if (reg_ptr == CHG_MASK_OFS) begin
                charge_event_mask <= shift_in;
            end
            if (reg_ptr == RAIL_MASK_OFS) begin
                rail_event_mask <= shift_in;
            end
        end
    end

    // Interrupt pin low while any bit is set, unmasked and unacknowledged.
    assign pending =
        |(charge_event_status & ~charge_event_mask & ~charge_event_ack) |
        |(rail_event_status & ~rail_event_mask & ~rail_event_ack);

    // Registered so the pin cannot glitch while status settles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_oe <= 1'b0;
        end else begin
            irq_oe <= pending;
        end
    end

    // Open drain: only the enable moves, the value stays low.
    assign irq_n_out = 1'b0;

    // Serial target: bits sampled on scl rise, sda changed on scl fall.
    // A read latches at the fall that ends the acknowledge before data;
    // a write lands at the fall that opens the data acknowledge.
    assign load_read = scl_fall && !start_seen && !stop_seen &&
        ((ser_state == SER_ACK_ADDR && read_dir) ||
         (ser_state == SER_ACK_READ && master_ack));
    assign wr_strobe = scl_fall && !start_seen && !stop_seen &&
        ser_state == SER_WRITE && bit_cnt == 4'(BYTE_BITS);

    // Phase machine; a START or STOP wins over any bit edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ser_state  <= SER_IDLE;
            shift_in   <= 8'h00;
            shift_out  <= 8'hff;
            bit_cnt    <= 4'h0;
            reg_ptr    <= 8'h00;
            read_dir   <= 1'b0;
            master_ack <= 1'b0;
        end else if (start_seen) begin
            ser_state <= SER_ADDR;
            bit_cnt   <= 4'h0;
        end else if (stop_seen) begin
            ser_state <= SER_IDLE;
        end else if (scl_rise) begin
            unique case (ser_state)
                SER_ADDR, SER_REG, SER_WRITE: begin
                    shift_in <= {shift_in[6:0], sda_s};
                    bit_cnt  <= bit_cnt + 4'h1;
                end
                SER_READ: begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
                SER_ACK_READ: begin
                    master_ack <= ~sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (ser_state)
                SER_ADDR: begin
                    if (bit_cnt == 4'(BYTE_BITS)) begin
                        bit_cnt  <= 4'h0;
                        read_dir <= shift_in[0];
                        if (shift_in[7:1] == {TARGET_ADDR_HI, strap_s}) begin
                            ser_state <= SER_ACK_ADDR;
                        end else begin
                            ser_state <= SER_IDLE;
                        end
                    end
                end
                SER_ACK_ADDR: begin
                    if (read_dir) begin
                        // Latch before shifting so no event is lost.
                        shift_out <= read_value(reg_ptr);
                        ser_state <= SER_READ;
                    end else begin
                        ser_state <= SER_REG;
                    end
                end
                SER_REG: begin
                    if (bit_cnt == 4'(BYTE_BITS)) begin
                        reg_ptr   <= shift_in;
                        bit_cnt   <= 4'h0;
                        ser_state <= SER_ACK_REG;
                    end
                end
                SER_ACK_REG, SER_ACK_WRITE: begin
                    ser_state <= SER_WRITE;
                end
                SER_WRITE: begin
                    if (bit_cnt == 4'(BYTE_BITS)) begin
                        bit_cnt   <= 4'h0;
                        ser_state <= SER_ACK_WRITE;
                    end
                end
                SER_READ: begin
                    if (bit_cnt == 4'(BYTE_BITS)) begin
                        bit_cnt   <= 4'h0;
                        ser_state <= SER_ACK_READ;
                    end else begin
                        shift_out <= {shift_out[6:0], 1'b1};
                    end
                end
                SER_ACK_READ: begin
                    if (master_ack) begin
                        shift_out <= read_value(reg_ptr);
                        ser_state <= SER_READ;
                    end else begin
                        ser_state <= SER_IDLE;
                    end
                end
                SER_IDLE: begin
                end
            endcase
        end
    end

    // Pull sda low for acknowledges and for zero bits of read data.
    // One bits are released so that the host pull-up sets them.
    assign sda_out = 1'b0;
    assign sda_oe  = (ser_state == SER_ACK_ADDR) ||
                     (ser_state == SER_ACK_REG) ||
                     (ser_state == SER_ACK_WRITE) ||
                     (ser_state == SER_READ && !shift_out[7]);

endmodule

// ===== tb/irq_status_props.sv
// Pin-level checks of the charger and rail interrupt status block.
// Assumes one clock, synchronous active-low reset and a slow serial host.
module irq_status_props
    import irq_status_pkg::*;
#(
    parameter int unsigned SYNC_STAGES = 2
) (
    // Clock and reset.
    input wire logic                         clk,
    input wire logic                         rst_n,
    // Serial pins.
    input wire logic                         scl_in,
    input wire logic                         sda_out,
    input wire logic                         sda_oe,
    // Condition sources.
    input wire irq_status_pkg::charger_src_t charger_src,
    input wire irq_status_pkg::rail_src_t    rail_src,
    input wire irq_status_pkg::rail_ctrl_t   rail_ctrl,
    // Outputs under check.
    input wire logic                         charger_reset,
    input wire logic                         irq_n_out,
    input wire logic                         irq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import irq_status_pkg::*;
    localparam int LAG = SYNC_STAGES + 6;
    logic       scl_d;
    logic [3:0] scl_age;
    logic [3:0] cause_age;

    // Cycles since the last scl fall, saturating.
    always_ff @(posedge clk) begin
        scl_d <= scl_in;
        if (!rst_n) begin
            scl_age <= 4'hf;
        end else if (scl_d && !scl_in) begin
            scl_age <= 4'h0;
        end else if (scl_age != 4'hf) begin
            scl_age <= scl_age + 4'h1;
        end
    end

    // Cycles since any source changed or scl fell, saturating.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cause_age <= 4'hf;
        end else if ($changed(charger_src) || $changed(rail_src) ||
                     $changed(rail_ctrl) || (scl_d && !scl_in)) begin
            cause_age <= 4'h0;
        end else if (cause_age != 4'hf) begin
            cause_age <= cause_age + 4'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_idle_pins;
        !irq_oe && !sda_oe && !charger_reset;
    endsequence
    sequence s_ack_soon;
        ##[0:8] sda_oe;
    endsequence

    a_sda_value_low: assert property (sda_out == 1'b0)
        else $error("sda output value not low");
    a_irq_value_low: assert property (irq_n_out == 1'b0)
        else $error("interrupt output value not low");
    a_release_quiet: assert property ($rose(rst_n) |-> s_idle_pins)
        else $error("outputs active at reset release");
    a_masked_after_reset: assert property (
        $rose(rst_n) |-> (!irq_oe) [*4])
        else $error("interrupt active while masked after reset");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda drive changed while scl high");
    a_sda_after_fall: assert property (
        $changed(sda_oe) |-> scl_age < LAG)
        else $error("sda drive changed without scl fall");
    a_pulse_one_cycle: assert property (
        charger_reset |=> !charger_reset)
        else $error("charger reset longer than one cycle");
    a_pulse_with_ack: assert property (charger_reset |-> s_ack_soon)
        else $error("charger reset without byte acknowledge");
    a_pulse_after_fall: assert property (
        charger_reset |-> scl_age < LAG)
        else $error("charger reset outside a serial write");
    a_irq_has_cause: assert property (
        $changed(irq_oe) |-> cause_age < LAG + 4)
        else $error("interrupt changed without a cause");
endmodule

bind charger_rail_irq_status irq_status_props #(
    .SYNC_STAGES(SYNC_STAGES)
) u_props (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .charger_src(charger_src), .rail_src(rail_src),
    .rail_ctrl(rail_ctrl), .charger_reset(charger_reset),
    .irq_n_out(irq_n_out), .irq_oe(irq_oe)
);

// ===== tb/host_model.sv
// Serial host model: drives scl and pulls sda low, quarter bit of 10 clk.
// Assumes the bench resolves sda from both pull-downs and a pull-up.
module host_model (
    // Clock and bus level.
    input  wire logic  clk,
    input  wire logic  sda,
    // Bus drive.
    output logic       scl,
    output logic       sda_pull,
    // Read result, one cycle.
    output logic       rd_valid,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 10;

    // Bus idle at time zero.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bit: b of 1 releases sda; r is the level seen with scl high.
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        tick(Q);
        scl <= 1'b1;
        tick(Q);
        r = sda;
        tick(Q);
        scl <= 1'b0;
        tick(Q);
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        tick(Q);
        scl <= 1'b1;
        tick(Q);
        sda_pull <= 1'b1;
        tick(Q);
        scl <= 1'b0;
        tick(Q);
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        tick(Q);
        scl <= 1'b1;
        tick(Q);
        sda_pull <= 1'b0;
        tick(Q);
    endtask
    // Byte sent MSB first, then the ninth bit a; k is its level.
    task automatic byte_io(input logic [7:0] d, input logic a,
                           output logic [7:0] r, output logic k);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            r[i] = b;
        end
        bit_io(a, k);
    endtask
    // Write d at offset o; nak is high when the target did not answer.
    task automatic wr(input logic [6:0] a, input logic [7:0] o, d,
                      output logic nak);
        logic [7:0] r;
        logic       k;
        start();
        byte_io({a, 1'b0}, 1'b1, r, nak);
        if (nak === 1'b0) begin
            byte_io(o, 1'b1, r, k);
            byte_io(d, 1'b1, r, k);
        end
        stop();
    endtask
    // Read one byte at offset o through a repeated start.
    task automatic rd(input logic [6:0] a, input logic [7:0] o);
        logic [7:0] r;
        logic       k;
        start();
        byte_io({a, 1'b0}, 1'b1, r, k);
        byte_io(o, 1'b1, r, k);
        start();
        byte_io({a, 1'b1}, 1'b1, r, k);
        byte_io(8'hff, 1'b1, r, k);
        rd_data <= r;
        rd_valid <= 1'b1;
        tick(1);
        rd_valid <= 1'b0;
        stop();
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the charger and rail interrupt status block.
// Assumes the host model on the serial pins and pull-ups on sda and irq.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_status_pkg::*;
    localparam int LIMIT = 80000;
    logic         clk, rst_n, strap, nak;
    charger_src_t csrc;
    rail_src_t    rsrc;
    rail_ctrl_t   rctl;
    logic         scl, hpull, rd_valid, sda_oe, sda_out;
    logic         chg_rst, irq_n_out, irq_oe;
    logic [7:0]   rd_data, v, e;
    logic [6:0]   adr, r7;
    logic [3:0]   k4;
    logic [7:0]   expq[$];
    int           fail_count, checks_done, pulses, cyc;
    wire          sda = ~(sda_oe | hpull);
    wire          irq_pin = ~irq_oe;

    charger_rail_irq_status uut (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_lsb_strap(strap), .charger_src(csrc), .rail_src(rsrc),
        .rail_ctrl(rctl), .charger_reset(chg_rst),
        .irq_n_out(irq_n_out), .irq_oe(irq_oe));
    host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(hpull),
        .rd_valid(rd_valid), .rd_data(rd_data));

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cmp_reg(input logic [7:0] g, x);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic cmp_pin(input logic g, x);
        cmp_reg({7'h00, g}, {7'h00, x});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] o, x);
        expq.push_back(x);
        host.rd(adr, o);
    endtask
    task automatic wr(input logic [7:0] o, d);
        host.wr(adr, o, d, nak);
    endtask

    // Pairs read results with notes, counts reset pulses, bounds the run.
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() > 0) begin
                cmp_reg(rd_data, expq.pop_front());
            end else begin
                // A result with no note waiting is a mismatch.
                fail_count++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, rd_data, 8'hxx);
            end
        end
        if (chg_rst === 1'b1) pulses++;
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            end_of_test();
        end
    end

    // Main sequence; the lid pin idles high, bit 5 of the rail sources.
    initial begin
        void'($urandom(32'h6a5e55de));
        rst_n = 1'b0;
        strap = 1'($urandom);
        csrc = '0;
        rsrc = 7'h20;
        rctl = '0;
        adr = {TARGET_ADDR_HI, strap};
        w(8);
        rst_n <= 1'b1;
        w(8);
        // Offsets 3, 4 and unmapped 7 read all ones, the rest zero.
        for (int i = 1; i <= 7; i++) begin
            e = (i inside {3, 4, 7}) ? 8'hff : 8'h00;
            rd(8'(i), e);
        end
        cmp_pin(irq_pin, 1'b1);
        host.wr({TARGET_ADDR_HI, ~strap}, CHG_MASK_OFS, 8'h00, nak);
        cmp_pin(nak, 1'b1);
        rd(CHG_MASK_OFS, 8'hff);
        $display("test reset done");
        v = 8'($urandom);
        csrc <= v;
        w(10);
        rd(CHG_STATUS_OFS, v);
        rd(CHG_ACK_OFS, v);
        wr(CHG_MASK_OFS, 8'h00);
        cmp_pin(nak, 1'b0);
        w(10);
        cmp_pin(irq_pin, 1'b1);
        csrc <= '0;
        w(10);
        rd(CHG_STATUS_OFS, 8'h00);
        rd(CHG_ACK_OFS, 8'h00);
        $display("test charger levels done");
        wr(CHG_MASK_OFS, 8'h20);
        csrc.thermal_suspend <= 1'b1;
        w(10);
        csrc.thermal_suspend <= 1'b0;
        w(10);
        cmp_pin(irq_pin, 1'b1);
        wr(CHG_MASK_OFS, 8'h00);
        cmp_pin(irq_pin, 1'b0);
        rd(CHG_STATUS_OFS, 8'h20);
        cmp_pin(irq_pin, 1'b1);
        rd(CHG_STATUS_OFS, 8'h00);
        $display("test edge capture done");
        csrc <= 8'h90;
        w(10);
        cmp_pin(irq_pin, 1'b0);
        wr(CHG_STATUS_OFS, 8'h00);
        cmp_pin(pulses == 1, 1'b1);
        rd(CHG_STATUS_OFS, 8'h80);
        csrc <= '0;
        $display("test charger clear done");
        wr(RAIL_MASK_OFS, 8'h00);
        r7 = 7'($urandom) | 7'h40;
        k4 = 4'($urandom);
        rsrc <= r7;
        rctl <= k4;
        e = {r7[6], ~r7[5], r7[4], 1'b0, r7[3] & k4[3], r7[2] & k4[2],
             r7[1], r7[0] | (k4[1] & k4[0])};
        w(10);
        cmp_pin(irq_pin, 1'b0);
        rd(RAIL_STATUS_OFS, e);
        rd(RAIL_ACK_OFS, e);
        cmp_pin(irq_pin, 1'b1);
        wr(RAIL_STATUS_OFS, 8'h00);
        rd(RAIL_STATUS_OFS, e);
        rsrc <= 7'h20;
        w(10);
        rd(RAIL_STATUS_OFS, {7'h00, k4[1] & k4[0]});
        $display("test rail done");
        end_of_test();
    end
endmodule
